// *** design/fact_cfg.svh ***
// constants for the fault alarm, cycle time and trace control block
// assumes inclusion by bare name from the design modules
`ifndef FACT_CFG_SVH
`define FACT_CFG_SVH

// ==========================================================================
// register byte offsets
`define FACT_OFF_ALARM 8'h00
`define FACT_OFF_CTRL 8'h04
`define FACT_OFF_TSEL 8'h08
`define FACT_OFF_TIVL 8'h0c
`define FACT_OFF_STAT 8'h10
`define FACT_OFF_MINC 8'h14

// ==========================================================================
// field positions
`define FACT_CTRL_SAMP_BIT 15
`define FACT_CTRL_TRACE_BIT 14
`define FACT_CTRL_CLRHALT_BIT 0
`define FACT_STAT_ERR_BIT 0
`define FACT_STAT_HALT_BIT 1
`define FACT_STAT_PAD_BIT 2
`define FACT_STAT_MSG_BIT 3
`define FACT_ALARM_FATAL_BIT 8

// ==========================================================================
// reset values
`define FACT_TSEL_RST 15'h7fff
`define FACT_TIVL_RST 10'h000
`define FACT_MINC_RST 10'h000

// ==========================================================================
// timing: one tenth of a millisecond at a 40 ns clock
`define FACT_TENTH_NS 100000
`define FACT_CLK_NS 40
`define FACT_TENTH_CYC (`FACT_TENTH_NS / `FACT_CLK_NS)
`define FACT_FLASH_TENTHS 5000

// ==========================================================================
// system alarm codes in recall order
`define FACT_SYS_9A 8'h9a
`define FACT_SYS_9B 8'h9b
`define FACT_SYS_9D 8'h9d
`define FACT_SYS_8A 8'h8a
`define FACT_SYS_8B 8'h8b

`endif

// *** design/fact_pkg.sv ***
// types shared by the fault alarm, cycle time and trace control block
// assumes fact_cfg.svh is on the include path
package fact_pkg;
  // instruction codes presented by the program executor
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_NFAL = 3'h1,
    OP_FATAL = 3'h2,
    OP_MINCYC = 3'h3,
    OP_TRSM = 3'h4,
    OP_MSG = 3'h5,
    OP_END = 3'h6,
    OP_TRACE_SET = 3'h7
  } fact_op_e;

  // cycle sequencer states, gray along run -> pad -> halt
  typedef enum logic [1:0] {
    CYC_RUN = 2'b00,
    CYC_PAD = 2'b01,
    CYC_HALT = 2'b11
  } fact_cyc_e;
endpackage

// *** design/fact_alarm_queue.sv ***
// alarm code queue: one code shown, all others pending in flops
// assumes post and recall are single-cycle strobes on pclk
`timescale 1ns/100ps
`include "fact_cfg.svh"
module fact_alarm_queue
  import fact_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests
  input wire logic post_valid,
  input wire logic [7:0] post_code,
  input wire logic recall,
  // shown code
  output logic [7:0] field
);
  logic [255:0] pend_ff;
  logic [7:0] field_ff;
  logic [7:0] nxt_sel;
  logic any_pend;
  logic direct;
  logic [7:0] nxt_field;

  // ==========================================================================
  // selection of the next code to show
  assign any_pend = |pend_ff;
  assign direct = post_valid & ((field_ff == 8'h00) | (recall & ~any_pend));

  // lowest priority first so that the highest one overwrites
  always_comb begin
    nxt_sel = 8'h00;
    for (int i = 99; i >= 1; i--) begin
      if (pend_ff[8'((i / 10) * 16 + (i % 10))]) begin
        nxt_sel = 8'((i / 10) * 16 + (i % 10));
      end
    end
    if (pend_ff[`FACT_SYS_8B]) nxt_sel = `FACT_SYS_8B;
    if (pend_ff[`FACT_SYS_8A]) nxt_sel = `FACT_SYS_8A;
    if (pend_ff[`FACT_SYS_9D]) nxt_sel = `FACT_SYS_9D;
    if (pend_ff[`FACT_SYS_9B]) nxt_sel = `FACT_SYS_9B;
    if (pend_ff[`FACT_SYS_9A]) nxt_sel = `FACT_SYS_9A;
  end

  // shown code: recall moves the next pending one up, else zero
  assign nxt_field = direct ? post_code :
                     recall ? (any_pend ? nxt_sel : 8'h00) : field_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_ff <= 8'h00;
    end else begin
      field_ff <= nxt_field;
    end
  end

  // ==========================================================================
  // one pending flag per code; a new post wins over a recall clear
  for (genvar g = 0; g < 256; g++) begin : g_pend
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_ff[g] <= 1'b0;
      end else if (post_valid && !direct && post_code == 8'(g) && field_ff != 8'(g)) begin
        pend_ff[g] <= 1'b1;
      end else if (recall && any_pend && nxt_sel == 8'(g)) begin
        pend_ff[g] <= 1'b0;
      end
    end
  end

  assign field = field_ff;

  // ==========================================================================
  // checks
  property p_sys_first;
    @(posedge pclk) disable iff (!presetn)
      (recall && !post_valid && pend_ff[`FACT_SYS_9A]) |=> (field == `FACT_SYS_9A);
  endproperty
  a_sys_first: assert property (p_sys_first) else $error("9a not recalled first");

  property p_kept;
    @(posedge pclk) disable iff (!presetn)
      (post_valid && field_ff != 8'h00 && !recall && post_code != field_ff)
        |=> pend_ff[$past(post_code)] && field == $past(field_ff);
  endproperty
  a_kept: assert property (p_kept) else $error("posted code not queued");
endmodule

// *** design/fact_ctl.sv ***
// fault alarm, minimum cycle time and trace sampling control
// assumes an apb master on pclk and a program executor on pclk
//
// Contract
// - alarm instruction with true condition writes its code to alarm field bits 7..0
// - only codes 01 to 99 from the definer operand are accepted
// - non-fatal alarm flashes the indicator and the cycle keeps running
// - fatal alarm lights the indicator steadily and halts operation
// - all pending codes are queued, one shown at a time; a user code posted in the same cycle as a system alarm is dropped
// - non-fatal alarm with code zero shows the next queued code
// - recall order: earliest, then 9a 9b 9d 8a 8b, then 01 to 99
// - the zero-code alarm also clears a posted user message
// - minimum cycle operand counts tenths of a millisecond
// - a short cycle is padded until the minimum has passed
// - a long cycle starts the next one with no padding
// - error flag on non-bcd operand or bad indirect word
// - sampling start bit and trace start bit govern trace sampling
// - trace sample instruction ignores its execution condition
// - trace start bit set records data; program or host may set it
// - a sample holds up to 12 bits and 3 words chosen by host
// - a sample is taken at each trace sample instruction; the code takes none while a host timer interval is set
// - with no trace sample instruction, sample at program end
// - a host timer interval samples regularly, apart from the cycle
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`include "fact_cfg.svh"
module fact_ctl
  import fact_pkg::*;
#(
  parameter int TRACE_BITS = 12,
  parameter int TRACE_WORDS = 3,
  parameter int FLASH_TENTHS = `FACT_FLASH_TENTHS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program executor
  input wire logic instr_valid,
  input wire fact_op_e instr_op,
  input wire logic instr_cond,
  input wire logic [15:0] instr_operand,
  input wire logic instr_ind_bad,
  // system alarms
  input wire logic sys_alarm_valid,
  input wire logic [7:0] sys_alarm_code,
  // cycle control
  output logic cycle_start,
  output logic halt,
  // alarm indication
  output logic [7:0] alarm_field,
  output logic alarm_led,
  output logic msg_posted,
  output logic instr_error_flag,
  // trace capture
  input wire logic [TRACE_BITS-1:0] trace_bits_in,
  input wire logic [TRACE_WORDS*16-1:0] trace_words_in,
  output logic trace_wr,
  output logic [TRACE_BITS-1:0] trace_bits,
  output logic [TRACE_WORDS*16-1:0] trace_words
);
  localparam logic [11:0] TENTH_CYC = 12'(`FACT_TENTH_CYC);

  logic samp_ff, trc_ff, halt_ff, err_ff, msg_ff, fatal_ff, led_ff, flash_ff;
  logic trsm_seen_ff, cyc_start_ff, trace_wr_ff;
  logic [14:0] tsel_ff;
  logic [9:0] tivl_ff, ivl_cnt_ff, min_ff, elapsed_ff;
  logic [11:0] tick_cnt_ff;
  logic [12:0] flash_cnt_ff;
  logic [31:0] prdata_ff;
  logic [TRACE_BITS-1:0] tbits_ff;
  logic [TRACE_WORDS*16-1:0] twords_ff;
  fact_cyc_e cyc_ff, nxt_cyc;
  logic [7:0] field_w;

  // ==========================================================================
  // apb decode
  wire wr_acc = psel & penable & pwrite;
  wire setup = psel & ~penable;
  wire hit_alarm = paddr == `FACT_OFF_ALARM;
  wire hit_ctrl = paddr == `FACT_OFF_CTRL;
  wire hit_tsel = paddr == `FACT_OFF_TSEL;
  wire hit_tivl = paddr == `FACT_OFF_TIVL;
  wire hit_stat = paddr == `FACT_OFF_STAT;
  wire hit_minc = paddr == `FACT_OFF_MINC;
  wire hit_any = hit_alarm | hit_ctrl | hit_tsel | hit_tivl | hit_stat | hit_minc;
  wire wr_ctrl = wr_acc & hit_ctrl;
  wire wr_stat = wr_acc & hit_stat;
  wire clr_halt = wr_ctrl & pwdata[`FACT_CTRL_CLRHALT_BIT];
  wire clr_err = wr_stat & pwdata[`FACT_STAT_ERR_BIT];

  // read data selection
  wire [31:0] rd_mux =
    hit_alarm ? {23'h0, fatal_ff, field_w} :
    hit_ctrl ? {16'h0, samp_ff, trc_ff, 14'h0} :
    hit_tsel ? {17'h0, tsel_ff} :
    hit_tivl ? {22'h0, tivl_ff} :
    hit_stat ? {28'h0, msg_ff, cyc_ff == CYC_PAD, halt_ff, err_ff} :
    hit_minc ? {22'h0, min_ff} : 32'h0;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_ff;

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (setup) begin
      prdata_ff <= rd_mux;
    end
  end

  // ==========================================================================
  // instruction decode
  wire is_nfal = instr_valid & (instr_op == OP_NFAL) & instr_cond;
  wire is_fatal = instr_valid & (instr_op == OP_FATAL) & instr_cond;
  wire is_minc = instr_valid & (instr_op == OP_MINCYC) & instr_cond;
  wire is_trsm = instr_valid & (instr_op == OP_TRSM);
  wire is_msg = instr_valid & (instr_op == OP_MSG) & instr_cond;
  wire is_end = instr_valid & (instr_op == OP_END);
  wire is_tset = instr_valid & (instr_op == OP_TRACE_SET);
  wire [7:0] code = instr_operand[7:0];
  wire code_ok = (code[7:4] <= 4'h9) & (code[3:0] <= 4'h9) & (code != 8'h00);
  wire recall = is_nfal & (code == 8'h00);
  wire usr_post = (is_nfal | is_fatal) & code_ok;
  wire post_valid = sys_alarm_valid | usr_post;
  wire [7:0] post_code = sys_alarm_valid ? sys_alarm_code : code;

  // ==========================================================================
  // alarm queue and field
  fact_alarm_queue u_queue (
    .pclk(pclk),
    .presetn(presetn),
    .post_valid(post_valid),
    .post_code(post_code),
    .recall(recall),
    .field(field_w)
  );
  assign alarm_field = field_w;

  // halt, message and fatal marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_ff <= 1'b0;
      fatal_ff <= 1'b0;
      msg_ff <= 1'b0;
    end else begin
      halt_ff <= (is_fatal & code_ok) | (halt_ff & ~clr_halt);
      fatal_ff <= (is_fatal & code_ok) | (fatal_ff & ~clr_halt);
      msg_ff <= is_msg | (msg_ff & ~recall);
    end
  end

  // ==========================================================================
  // tenth-of-millisecond tick
  wire tenth_tick = tick_cnt_ff == TENTH_CYC - 12'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 12'h0;
    end else begin
      tick_cnt_ff <= tenth_tick ? 12'h0 : tick_cnt_ff + 12'd1;
    end
  end

  // indicator: steady while halted, flashing while a code is shown
  wire flash_wrap = flash_cnt_ff == 13'(FLASH_TENTHS - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_ff <= 13'h0;
      flash_ff <= 1'b0;
      led_ff <= 1'b0;
    end else begin
      if (tenth_tick) begin
        flash_cnt_ff <= flash_wrap ? 13'h0 : flash_cnt_ff + 13'd1;
      end
      if (tenth_tick && flash_wrap) begin
        flash_ff <= ~flash_ff;
      end
      led_ff <= halt_ff | ((field_w != 8'h00) & flash_ff);
    end
  end

  // ==========================================================================
  // minimum cycle operand: bcd check and three-digit conversion
  wire bcd_ok = (instr_operand[15:12] <= 4'h9) & (instr_operand[11:8] <= 4'h9) &
                (instr_operand[7:4] <= 4'h9) & (instr_operand[3:0] <= 4'h9);
  wire [9:0] mi_bin = 10'({6'h0, instr_operand[11:8]} * 10'd100 +
                          {6'h0, instr_operand[7:4]} * 10'd10 +
                          {6'h0, instr_operand[3:0]});
  wire min_bad = is_minc & (~bcd_ok | instr_ind_bad);

  // error flag: a new error wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ff <= 1'b0;
      min_ff <= `FACT_MINC_RST;
    end else begin
      err_ff <= min_bad | (err_ff & ~clr_err);
      if (is_minc && !min_bad) begin
        min_ff <= mi_bin;
      end
    end
  end

  // ==========================================================================
  // cycle sequencer: pads short cycles, waits out a halt
  wire min_met = elapsed_ff >= min_ff;
  wire go = (cyc_ff == CYC_RUN & is_end & min_met) | (cyc_ff == CYC_PAD & min_met) |
            (cyc_ff == CYC_HALT & ~halt_ff);

  always_comb begin
    nxt_cyc = cyc_ff;
    case (cyc_ff)
      CYC_RUN: begin
        if (halt_ff) begin
          nxt_cyc = CYC_HALT;
        end else if (is_end && !min_met) begin
          nxt_cyc = CYC_PAD;
        end
      end
      CYC_PAD: begin
        if (halt_ff) begin
          nxt_cyc = CYC_HALT;
        end else if (min_met) begin
          nxt_cyc = CYC_RUN;
        end
      end
      CYC_HALT: begin
        if (!halt_ff) begin
          nxt_cyc = CYC_RUN;
        end
      end
      default: begin
        nxt_cyc = CYC_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_ff <= CYC_RUN;
      cyc_start_ff <= 1'b0;
      elapsed_ff <= 10'h0;
    end else begin
      cyc_ff <= nxt_cyc;
      cyc_start_ff <= go & ~halt_ff;
      if (go) begin
        elapsed_ff <= 10'h0;
      end else if (tenth_tick && elapsed_ff != 10'h3ff) begin
        elapsed_ff <= elapsed_ff + 10'd1;
      end
    end
  end

  assign cycle_start = cyc_start_ff;
  assign halt = halt_ff;
  assign alarm_led = led_ff;
  assign msg_posted = msg_ff;
  assign instr_error_flag = err_ff;

  // ==========================================================================
  // trace control bits and host settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_ff <= 1'b0;
      trc_ff <= 1'b0;
      tsel_ff <= `FACT_TSEL_RST;
      tivl_ff <= `FACT_TIVL_RST;
    end else begin
      if (wr_ctrl) begin
        samp_ff <= pwdata[`FACT_CTRL_SAMP_BIT];
      end
      if (is_tset) begin
        trc_ff <= instr_cond;
      end else if (wr_ctrl) begin
        trc_ff <= pwdata[`FACT_CTRL_TRACE_BIT];
      end
      if (wr_acc && hit_tsel) begin
        tsel_ff <= pwdata[14:0];
      end
      if (wr_acc && hit_tivl) begin
        tivl_ff <= pwdata[9:0];
      end
    end
  end

  // ==========================================================================
  // trace triggers
  wire armed = samp_ff & trc_ff;
  wire ivl_on = tivl_ff != 10'h0;
  wire ivl_hit = ivl_on & tenth_tick & (ivl_cnt_ff >= tivl_ff - 10'd1);
  wire end_smp = is_end & ~trsm_seen_ff;
  wire trig = armed & (ivl_on ? ivl_hit : (is_trsm | end_smp));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ivl_cnt_ff <= 10'h0;
      trsm_seen_ff <= 1'b0;
    end else begin
      if (!ivl_on || ivl_hit) begin
        ivl_cnt_ff <= 10'h0;
      end else if (tenth_tick) begin
        ivl_cnt_ff <= ivl_cnt_ff + 10'd1;
      end
      trsm_seen_ff <= trsm_seen_ff | is_trsm;
    end
  end

  // ==========================================================================
  // sample capture, masked by the host's selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_wr_ff <= 1'b0;
      tbits_ff <= '0;
    end else begin
      trace_wr_ff <= trig;
      if (trig) begin
        tbits_ff <= trace_bits_in & tsel_ff[TRACE_BITS-1:0];
      end
    end
  end

  // one capture word per trace word, zero unless selected by the host
  for (genvar w = 0; w < TRACE_WORDS; w++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        twords_ff[w*16 +: 16] <= 16'h0;
      end else if (trig) begin
        twords_ff[w*16 +: 16] <= tsel_ff[TRACE_BITS + w] ? trace_words_in[w*16 +: 16] : 16'h0;
      end
    end
  end

  assign trace_wr = trace_wr_ff;
  assign trace_bits = tbits_ff;
  assign trace_words = twords_ff;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alarm_write;
    (usr_post && !sys_alarm_valid && field_w == 8'h00) |=> (alarm_field == $past(code));
  endproperty
  a_alarm_write: assert property (p_alarm_write) else $error("code not shown");

  property p_bad_code;
    ((is_nfal || is_fatal) && !code_ok && !recall && !sys_alarm_valid)
      |=> (alarm_field == $past(alarm_field)) && (halt == $past(halt));
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code accepted");

  property p_nfal_runs;
    (is_nfal && !halt_ff) |=> !halt;
  endproperty
  a_nfal_runs: assert property (p_nfal_runs) else $error("non-fatal alarm halted");

  property p_fatal_halt;
    (is_fatal && code_ok) |=> halt ##1 alarm_led;
  endproperty
  a_fatal_halt: assert property (p_fatal_halt) else $error("fatal alarm did not halt");

  property p_msg_clear;
    (recall && !is_msg) |=> !msg_posted;
  endproperty
  a_msg_clear: assert property (p_msg_clear) else $error("message not cleared");

  property p_err_set;
    (is_minc && !bcd_ok) |=> instr_error_flag && min_ff == $past(min_ff);
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flag not set");

  property p_pad;
    (cyc_ff == CYC_RUN && is_end && !min_met && !halt_ff) |=> !cycle_start;
  endproperty
  a_pad: assert property (p_pad) else $error("short cycle not padded");

  property p_no_pad;
    (cyc_ff == CYC_RUN && is_end && min_met && !halt_ff) |=> cycle_start;
  endproperty
  a_no_pad: assert property (p_no_pad) else $error("long cycle padded");

  property p_gate;
    !armed |=> !trace_wr;
  endproperty
  a_gate: assert property (p_gate) else $error("sample while not armed");

  property p_trsm_free;
    (is_trsm && !instr_cond && armed && !ivl_on) |=> trace_wr;
  endproperty
  a_trsm_free: assert property (p_trsm_free) else $error("sample needs condition");
endmodule

// *** bench/fact_prog_model.sv ***
// program executor and system alarm source facing the control block
// assumes tasks are called from one bench process, synchronous to pclk
`timescale 1ns/100ps
module fact_prog_model
  import fact_pkg::*;
(
  // clock
  input wire logic pclk,
  // instruction stream
  output logic instr_valid,
  output fact_op_e instr_op,
  output logic instr_cond,
  output logic [15:0] instr_operand,
  output logic instr_ind_bad,
  // system alarms
  output logic sys_alarm_valid,
  output logic [7:0] sys_alarm_code
);
  // ==========
  // idle values at time zero
  initial begin
    instr_valid = 1'b0;
    instr_op = OP_NONE;
    instr_cond = 1'b0;
    instr_operand = 16'h0000;
    instr_ind_bad = 1'b0;
    sys_alarm_valid = 1'b0;
    sys_alarm_code = 8'h00;
  end

  // one instruction for one cycle; each code used with one alarm kind only
  // no instruction sets the sampling start bit, that stays with the host
  task automatic run(input fact_op_e op, input logic c, input logic [15:0] d);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_cond <= c;
    instr_operand <= d;
    @(posedge pclk);
    instr_valid <= 1'b0;
    instr_operand <= ~d; // released operand carries no stale value
  endtask

  // one instruction whose indirectly addressed word is missing
  task automatic run_ind(input fact_op_e op, input logic [15:0] d);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_cond <= 1'b1;
    instr_operand <= d;
    instr_ind_bad <= 1'b1;
    @(posedge pclk);
    instr_valid <= 1'b0;
    instr_ind_bad <= 1'b0;
  endtask

  // one system alarm pulse
  task automatic sys(input logic [7:0] code);
    @(posedge pclk);
    sys_alarm_valid <= 1'b1;
    sys_alarm_code <= code;
    @(posedge pclk);
    sys_alarm_valid <= 1'b0;
    sys_alarm_code <= ~code;
  endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the alarm, cycle time and trace control block
// assumes the design files and the program model are compiled first
`timescale 1ns/100ps
module tb_top
  import fact_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic instr_valid, instr_cond, instr_ind_bad, sys_alarm_valid;
  fact_op_e instr_op;
  logic [15:0] instr_operand;
  logic [7:0] sys_alarm_code, alarm_field;
  logic cycle_start, halt, alarm_led, msg_posted, instr_error_flag, trace_wr;
  logic [11:0] trace_bits_in = 12'ha5c;
  logic [47:0] trace_words_in = 48'h1234_5678_9abc;
  logic [11:0] trace_bits;
  logic [47:0] trace_words;
  int fail_count = 0;
  int n_compared = 0;
  int n;

  // ==========
  // clock and parts
  always #20 pclk = ~pclk;
  fact_ctl #(.FLASH_TENTHS(4)) fact_ctl_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_op(instr_op), .instr_cond(instr_cond),
    .instr_operand(instr_operand), .instr_ind_bad(instr_ind_bad),
    .sys_alarm_valid(sys_alarm_valid), .sys_alarm_code(sys_alarm_code),
    .cycle_start(cycle_start), .halt(halt), .alarm_field(alarm_field),
    .alarm_led(alarm_led), .msg_posted(msg_posted),
    .instr_error_flag(instr_error_flag), .trace_bits_in(trace_bits_in),
    .trace_words_in(trace_words_in), .trace_wr(trace_wr),
    .trace_bits(trace_bits), .trace_words(trace_words));
  fact_prog_model prog_i (.pclk(pclk), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_cond(instr_cond), .instr_operand(instr_operand),
    .instr_ind_bad(instr_ind_bad), .sys_alarm_valid(sys_alarm_valid),
    .sys_alarm_code(sys_alarm_code));

  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] x);
    n_compared++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask

  // apb transfer: setup, access held until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles until the next cycle start pulse
  task automatic wait_cs(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (cycle_start !== 1'b1 && c < 9000);
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic s_reset();
    chk("field idle", alarm_field, 8'h00);
    apb(1'b0, 8'h08, 32'h0);
    chk("tsel reset", q, 32'h7fff);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", e, 1'b1);
  endtask

  task automatic s_alarm();
    logic l;
    prog_i.run(OP_NFAL, 1'b1, 16'h0012);
    #1 chk("field post", alarm_field, 8'h12);
    chk("no halt", halt, 1'b0);
    // the indicator must toggle while the code stays shown
    repeat (2) @(posedge pclk);
    l = alarm_led;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (alarm_led === l && n < 10100);
    chk("led flash", alarm_led, !l);
    prog_i.run(OP_NFAL, 1'b1, 16'h00a5);
    prog_i.run(OP_NFAL, 1'b0, 16'h0077);
    prog_i.run(OP_NFAL, 1'b1, 16'h0034);
    prog_i.sys(8'h9b);
    prog_i.sys(8'h9a);
    prog_i.run(OP_MSG, 1'b1, 16'h0000);
    #1 chk("field held", alarm_field, 8'h12);
    chk("msg on", msg_posted, 1'b1);
    prog_i.run(OP_NFAL, 1'b1, 16'h0000);
    #1 chk("recall sys", alarm_field, 8'h9a);
    chk("msg off", msg_posted, 1'b0);
    prog_i.run(OP_NFAL, 1'b1, 16'h0000);
    #1 chk("recall sys 2", alarm_field, 8'h9b);
    prog_i.run(OP_NFAL, 1'b1, 16'h0000);
    #1 chk("recall user", alarm_field, 8'h34);
    prog_i.run(OP_NFAL, 1'b1, 16'h0000);
    #1 chk("queue empty", alarm_field, 8'h00);
  endtask

  task automatic s_fatal();
    prog_i.run(OP_FATAL, 1'b1, 16'h0056);
    #1 chk("halt", halt, 1'b1);
    chk("fatal code", alarm_field, 8'h56);
    @(posedge pclk);
    #1 chk("led steady", alarm_led, 1'b1);
    apb(1'b1, 8'h04, 32'h1);
    repeat (2) @(posedge pclk);
    #1 chk("halt clear", halt, 1'b0);
    prog_i.run(OP_NFAL, 1'b1, 16'h0000);
  endtask

  task automatic s_cycle();
    prog_i.run(OP_MINCYC, 1'b1, 16'h00a1);
    #1 chk("bcd err", instr_error_flag, 1'b1);
    apb(1'b1, 8'h10, 32'h1);
    prog_i.run(OP_MINCYC, 1'b1, 16'h1002);
    #1 chk("err cleared", instr_error_flag, 1'b0);
    prog_i.run_ind(OP_MINCYC, 16'h0005);
    #1 chk("ind err", instr_error_flag, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    chk("min digits", q, 32'h2);
    prog_i.run(OP_END, 1'b1, 16'h0000);
    wait_cs(n);
    chk("padded", (n > 2400 && n <= 5100), 1'b1);
    repeat (7600) @(posedge pclk);
    prog_i.run(OP_END, 1'b1, 16'h0000);
    wait_cs(n);
    chk("no pad", (n <= 2), 1'b1);
  endtask

  task automatic s_trace();
    prog_i.run(OP_END, 1'b1, 16'h0000);
    #1 chk("unarmed end", trace_wr, 1'b0);
    apb(1'b1, 8'h04, 32'hc000);
    prog_i.run(OP_END, 1'b1, 16'h0000);
    #1 chk("end sample", trace_wr, 1'b1);
    apb(1'b1, 8'h04, 32'h0);
    prog_i.run(OP_TRSM, 1'b1, 16'h0000);
    #1 chk("unarmed", trace_wr, 1'b0);
    // host arms sampling, the program sets the trace start bit
    apb(1'b1, 8'h04, 32'h8000);
    prog_i.run(OP_TRACE_SET, 1'b1, 16'h0000);
    prog_i.run(OP_TRSM, 1'b0, 16'h0000);
    #1 chk("sample", trace_wr, 1'b1);
    chk("bits", trace_bits, 12'ha5c);
    chk("words", trace_words, 48'h1234_5678_9abc);
    prog_i.run(OP_END, 1'b1, 16'h0000);
    #1 chk("end after trsm", trace_wr, 1'b0);
    // timer interval of one tenth replaces instruction sampling
    apb(1'b1, 8'h0c, 32'h1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (trace_wr !== 1'b1 && n < 2600);
    chk("timer sample", trace_wr, 1'b1);
    prog_i.run(OP_TRSM, 1'b1, 16'h0000);
    #1 chk("timer only", trace_wr, 1'b0);
  endtask

  // ==========
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_alarm();
    s_fatal();
    s_cycle();
    s_trace();
    give_verdict();
  end

  initial begin
    #(40 * 40000);
    fail_count++;
    give_verdict();
  end
endmodule
